/* File: acs_defs.vh */
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

`define ACS_ADDR_CTRL1 16'h0001
`define ACS_ADDR_CTRL2 16'h0002
`define ACS_ADDR_OFFSET 16'h0003
`define ACS_ADDR_GAIN 16'h0004
`define ACS_ADDR_THRESH 16'h0005

`define ACS_RST_OFFSET 16'h0000
`define ACS_RST_GAIN 16'ha000
`define ACS_RST_THRESH 16'hcccc
`define ACS_RST_DECIM 3'h2
`define ACS_RST_BYPN 1'b1
`define ACS_RST_REDPWR 1'b0

`define ACS_C1_DL 15
`define ACS_C1_RD_OVR 14
`define ACS_C1_RD_GAIN 13
`define ACS_C1_RD_OFF 12
`define ACS_C1_RD_STAT 11
`define ACS_C1_FLEN_HI 8
`define ACS_C1_FLEN_LO 5
`define ACS_C1_BYPN 4
`define ACS_DECIM_HI 2
`define ACS_C2_REDPWR 2

`define ACS_ST_PART_HI 15
`define ACS_ST_DIE_HI 13
`define ACS_ST_VALID 10
`define ACS_ST_REDPWR 9
`define ACS_ST_OVR 8
`define ACS_ST_LOAD_MATCH 7
`define ACS_ST_FOK 6
`define ACS_ST_UFILT 5
`define ACS_ST_SKIP 4
`define ACS_ST_ONE 3

`define ACS_FAST_OVR_RUN 3'h4
`define ACS_COEF_STEP 8

`endif

/* File: acs_correct.v */
`timescale 1ns/1ns
`default_nettype none
module acs_correct #(
	parameter DW = 24
) (
	input wire ref_clk,
	input wire rst,
	input wire in_valid,
	input wire signed [DW-1:0] in_data,
	input wire [15:0] gain,
	input wire [15:0] offset,
	output reg out_valid_reg,
	output reg signed [DW-1:0] out_data_reg
);
	reg stage_valid_reg;
	reg signed [DW+1:0] scaled_reg;
	wire signed [DW+17:0] product;
	wire signed [DW+2:0] summed;
	wire signed [DW+1:0] scaled_next;

	function [DW-1:0] sat;
		input signed [DW+2:0] v;
		begin
			if (v > $signed({{4{1'b0}}, {(DW-1){1'b1}}}))
				sat = {1'b0, {(DW-1){1'b1}}};
			else if (v < $signed({{4{1'b1}}, {(DW-1){1'b0}}}))
				sat = {1'b1, {(DW-1){1'b0}}};
			else
				sat = v[DW-1:0];
		end
	endfunction

	assign product = in_data * $signed({1'b0, gain});
	assign scaled_next = product[DW+16:15];
	// offset full code is 1/128 fs
	assign summed = {scaled_reg[DW+1], scaled_reg} +
		{{(DW-14){offset[15]}}, offset, 1'b0};

	always @(posedge ref_clk) begin
		if (rst) begin
			stage_valid_reg <= 1'b0;
			scaled_reg <= {(DW+2){1'b0}};
			out_valid_reg <= 1'b0;
			out_data_reg <= {DW{1'b0}};
		end else begin
			stage_valid_reg <= in_valid;
			if (in_valid)
				scaled_reg <= scaled_next;
			out_valid_reg <= stage_valid_reg;
			if (stage_valid_reg)
				out_data_reg <= sat(summed);
		end
	end
endmodule
`default_nettype wire

/* File: acs_regs.v */
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.vh"
module acs_regs #(
	parameter DW = 24,
	// arbitrary identification values
	parameter [1:0] PART_CODE = 2'h1,
	parameter [2:0] DIE_INDEX = 3'h0,
	parameter COEF_STEP = `ACS_COEF_STEP
) (
	input wire ref_clk,
	input wire rst,
	input wire host_word_valid,
	input wire [15:0] host_word,
	input wire host_read,
	input wire conversion_valid_flag,
	input wire dec1_valid,
	input wire signed [DW-1:0] dec1_data,
	input wire mod_valid,
	input wire mod_full_scale,
	input wire coef_pass_valid,
	input wire [15:0] coef_pass_word,
	input wire coef_pass_last,
	input wire result_valid,
	input wire signed [DW-1:0] result_data,
	output reg read_word_valid_reg,
	output reg read_is_reg_reg,
	output reg [15:0] read_word_reg,
	output wire corr_valid,
	output wire signed [DW-1:0] corr_data,
	output reg overrange_reg,
	output reg download_active_reg,
	output reg user_filter_reg
);
	localparam ST_ADDR = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_COEF = 2'h2;
	localparam ST_SUM = 2'h3;

	localparam SEL_NONE = 3'h0;
	localparam SEL_STAT = 3'h1;
	localparam SEL_OFF = 3'h2;
	localparam SEL_GAIN = 3'h3;
	localparam SEL_OVR = 3'h4;

	reg [1:0] state_reg;
	reg [15:0] addr_reg;
	reg [15:0] offset_correction_reg;
	reg [15:0] gain_correction_reg;
	reg [15:0] overload_threshold_reg;
	reg [2:0] decimation_select_reg;
	reg fir_pass_reg;
	reg reduced_power_flag_reg;
	reg [2:0] read_sel_reg;
	reg [9:0] coef_left_reg;
	reg [15:0] dl_sum_reg;
	reg [15:0] dl_checksum_reg;
	reg download_checksum_match_reg;
	reg [15:0] pass_sum_reg;
	reg filter_ok_reg;
	reg [2:0] fast_run_reg;
	reg [15:0] status_word;
	reg [15:0] sel_word;
	wire [15:0] dec1_mag_top;
	wire thresh_over;
	wire fast_over;
	wire ctrl1_write;
	wire [15:0] pass_sum_next;

	function [9:0] coef_count;
		input [3:0] flen;
		begin
			coef_count = (flen + 10'h001) * COEF_STEP[9:0];
		end
	endfunction

	function [15:0] add16;
		input [15:0] a;
		input [15:0] b;
		begin
			add16 = a + b;
		end
	endfunction

	// magnitude scaled to the threshold's 16 bits;
	// most negative code has no positive twin, so it pins to full scale
	function [15:0] mag_top;
		input [DW-1:0] s;
		reg [DW-1:0] m;
		begin
			m = s[DW-1] ? (~s + {{(DW-1){1'b0}}, 1'b1}) : s;
			if (m[DW-1])
				mag_top = 16'hffff;
			else
				mag_top = m[DW-2:DW-17];
		end
	endfunction

	// several select bits in one word: status, then offset, gain, threshold
	function [2:0] read_select;
		input [15:0] w;
		begin
			if (w[`ACS_C1_RD_STAT])
				read_select = SEL_STAT;
			else if (w[`ACS_C1_RD_OFF])
				read_select = SEL_OFF;
			else if (w[`ACS_C1_RD_GAIN])
				read_select = SEL_GAIN;
			else if (w[`ACS_C1_RD_OVR])
				read_select = SEL_OVR;
			else
				read_select = SEL_NONE;
		end
	endfunction

	// status word assembly
	always @* begin
		status_word = 16'h0000;
		status_word[`ACS_ST_PART_HI:`ACS_ST_PART_HI-1] = PART_CODE;
		status_word[`ACS_ST_DIE_HI:`ACS_ST_DIE_HI-2] = DIE_INDEX;
		status_word[`ACS_ST_VALID] = conversion_valid_flag;
		status_word[`ACS_ST_REDPWR] = reduced_power_flag_reg;
		status_word[`ACS_ST_OVR] = overrange_reg;
		status_word[`ACS_ST_LOAD_MATCH] = download_checksum_match_reg;
		status_word[`ACS_ST_FOK] = filter_ok_reg;
		status_word[`ACS_ST_UFILT] = user_filter_reg;
		status_word[`ACS_ST_SKIP] = ~fir_pass_reg;
		status_word[`ACS_ST_ONE] = 1'b1;
		status_word[`ACS_DECIM_HI:0] = decimation_select_reg;
	end

	always @* begin
		case (read_sel_reg)
			SEL_STAT:
				sel_word = status_word;
			SEL_OFF:
				sel_word = offset_correction_reg;
			SEL_GAIN:
				sel_word = gain_correction_reg;
			SEL_OVR:
				sel_word = overload_threshold_reg;
			default:
				sel_word = result_data[DW-1:DW-16];
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_ADDR;
			addr_reg <= 16'h0000;
			offset_correction_reg <= `ACS_RST_OFFSET;
			gain_correction_reg <= `ACS_RST_GAIN;
			overload_threshold_reg <= `ACS_RST_THRESH;
			decimation_select_reg <= `ACS_RST_DECIM;
			fir_pass_reg <= `ACS_RST_BYPN;
			reduced_power_flag_reg <= `ACS_RST_REDPWR;
			coef_left_reg <= 10'h000;
			dl_sum_reg <= 16'h0000;
			dl_checksum_reg <= 16'h0000;
			download_checksum_match_reg <= 1'b0;
			download_active_reg <= 1'b0;
			user_filter_reg <= 1'b0;
		end else if (host_word_valid) begin
			case (state_reg)
				ST_ADDR: begin
					addr_reg <= host_word;
					state_reg <= ST_DATA;
				end
				ST_DATA: begin
					state_reg <= ST_ADDR;
					case (addr_reg)
						`ACS_ADDR_CTRL1: begin
							decimation_select_reg <= host_word[`ACS_DECIM_HI:0];
							fir_pass_reg <= host_word[`ACS_C1_BYPN];
							if (host_word[`ACS_C1_DL]) begin
								// a new download withdraws the old coefficients
								state_reg <= ST_COEF;
								coef_left_reg <=
									coef_count(host_word[`ACS_C1_FLEN_HI:`ACS_C1_FLEN_LO]);
								dl_sum_reg <= 16'h0000;
								download_checksum_match_reg <= 1'b0;
								download_active_reg <= 1'b1;
								user_filter_reg <= 1'b0;
							end
						end
						`ACS_ADDR_CTRL2:
							reduced_power_flag_reg <= host_word[`ACS_C2_REDPWR];
						`ACS_ADDR_OFFSET:
							offset_correction_reg <= host_word;
						`ACS_ADDR_GAIN:
							gain_correction_reg <= host_word;
						`ACS_ADDR_THRESH:
							overload_threshold_reg <= host_word;
						default:
							addr_reg <= addr_reg;
					endcase
				end
				// words carry no tag: a dropped one shifts the rest until reset
				ST_COEF: begin
					dl_sum_reg <= add16(dl_sum_reg, host_word);
					coef_left_reg <= coef_left_reg - 10'h001;
					if (coef_left_reg == 10'h001)
						state_reg <= ST_SUM;
				end
				ST_SUM: begin
					dl_checksum_reg <= host_word;
					download_checksum_match_reg <= (host_word == dl_sum_reg);
					download_active_reg <= 1'b0;
					user_filter_reg <= 1'b1;
					state_reg <= ST_ADDR;
				end
				default:
					state_reg <= ST_ADDR;
			endcase
		end
	end

	// control word 1 landing this cycle
	assign ctrl1_write = host_word_valid && (state_reg == ST_DATA) &&
		(addr_reg == `ACS_ADDR_CTRL1);

	always @(posedge ref_clk) begin
		if (rst) begin
			read_sel_reg <= SEL_NONE;
			read_word_valid_reg <= 1'b0;
			read_is_reg_reg <= 1'b0;
			read_word_reg <= 16'h0000;
		end else begin
			read_word_valid_reg <= host_read;
			if (host_read) begin
				read_word_reg <= sel_word;
				read_is_reg_reg <= (read_sel_reg != SEL_NONE);
			end
			// a select written with the read in the same cycle still wins
			if (ctrl1_write && read_select(host_word) != SEL_NONE)
				read_sel_reg <= read_select(host_word);
			else if (host_read)
				read_sel_reg <= SEL_NONE;
		end
	end

	assign pass_sum_next = add16(pass_sum_reg, coef_pass_word);

	always @(posedge ref_clk) begin
		if (rst) begin
			pass_sum_reg <= 16'h0000;
			filter_ok_reg <= 1'b0;
		end else if (!user_filter_reg) begin
			pass_sum_reg <= 16'h0000;
			filter_ok_reg <= 1'b0;
		end else if (coef_pass_valid) begin
			if (coef_pass_last) begin
				pass_sum_reg <= 16'h0000;
				filter_ok_reg <= (pass_sum_next == dl_checksum_reg);
			end else begin
				pass_sum_reg <= pass_sum_next;
			end
		end
	end

	assign dec1_mag_top = mag_top(dec1_data);
	assign thresh_over = (dec1_mag_top > overload_threshold_reg);
	assign fast_over = mod_valid && mod_full_scale && (fast_run_reg == `ACS_FAST_OVR_RUN);

	always @(posedge ref_clk) begin
		if (rst) begin
			fast_run_reg <= 3'h0;
			overrange_reg <= 1'b0;
		end else begin
			if (mod_valid) begin
				if (!mod_full_scale)
					fast_run_reg <= 3'h0;
				else if (fast_run_reg != `ACS_FAST_OVR_RUN)
					fast_run_reg <= fast_run_reg + 3'h1;
			end
			// threshold compare level
			// a fast hit in the same cycle keeps the flag up over a low sample
			if (dec1_valid) begin
				overrange_reg <= thresh_over || fast_over;
			end else if (fast_over) begin
				overrange_reg <= 1'b1;
			end
		end
	end

	acs_correct #(
		.DW(DW)
	) u_correct (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(result_valid),
		.in_data(result_data),
		.gain(gain_correction_reg),
		.offset(offset_correction_reg),
		.out_valid_reg(corr_valid),
		.out_data_reg(corr_data)
	);
endmodule
`default_nettype wire

/* File: acs_regs_props.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_regs_props #(
	parameter DW = 24
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_word_valid,
	input wire logic [15:0] host_word,
	input wire logic host_read,
	input wire logic conversion_valid_flag,
	input wire logic dec1_valid,
	input wire logic signed [DW-1:0] dec1_data,
	input wire logic mod_valid,
	input wire logic mod_full_scale,
	input wire logic coef_pass_valid,
	input wire logic [15:0] coef_pass_word,
	input wire logic coef_pass_last,
	input wire logic result_valid,
	input wire logic signed [DW-1:0] result_data,
	input wire logic read_word_valid_reg,
	input wire logic read_is_reg_reg,
	input wire logic [15:0] read_word_reg,
	input wire logic corr_valid,
	input wire logic signed [DW-1:0] corr_data,
	input wire logic overrange_reg,
	input wire logic download_active_reg,
	input wire logic user_filter_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (host_read |=> read_word_valid_reg)
		else $error("read not answered");
	a_read_unasked: assert property (!host_read |=> !read_word_valid_reg)
		else $error("read word without request");
	a_corr_latency: assert property (result_valid |-> ##2 corr_valid)
		else $error("corrected result late");
	a_corr_unasked: assert property (!result_valid |-> ##2 !corr_valid)
		else $error("corrected result without input");
	a_fast_overrange: assert property ((mod_valid && mod_full_scale) [*5] |-> ##[1:2] overrange_reg)
		else $error("fast overrange missed");
	a_ovr_cause: assert property ($rose(overrange_reg) |-> $past(dec1_valid || mod_full_scale))
		else $error("overrange set without sample");
	a_ovr_clear: assert property ($fell(overrange_reg) |-> $past(dec1_valid))
		else $error("overrange cleared without sample");
	a_uf_on_checksum: assert property ($rose(user_filter_reg) |-> $fell(download_active_reg))
		else $error("custom filter flag not tied to download end");
	a_dl_start: assert property ($rose(download_active_reg) |-> $past(host_word_valid && host_word[15]))
		else $error("download started without request");
endmodule
bind acs_regs acs_regs_props #(.DW(DW)) chk (.*);
`default_nettype wire

/* File: acs_host.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_host (
	input wire logic ref_clk,
	output logic host_word_valid,
	output logic [15:0] host_word,
	output logic host_read,
	input wire logic read_word_valid_reg,
	input wire logic [15:0] read_word_reg
);
	initial begin
		host_word_valid = 1'b0;
		host_word = 16'h0000;
		host_read = 1'b0;
	end
	task automatic put(input logic [15:0] v);
		@(negedge ref_clk);
		host_word_valid = 1'b1;
		host_word = v;
		@(negedge ref_clk);
		host_word_valid = 1'b0;
		// released bus shows a changed value, not a stale one
		host_word = ~v;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		put(a);
		put(d);
	endtask
	task automatic rd(input logic [15:0] sel, output logic [15:0] w);
		if (sel != 16'h0000) wr(16'h0001, sel);
		@(negedge ref_clk);
		host_read = 1'b1;
		@(negedge ref_clk);
		host_read = 1'b0;
		w = read_word_valid_reg ? read_word_reg : 16'hxxxx;
	endtask
endmodule
`default_nettype wire

/* File: acs_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_regs_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cvf = 1'b0, dv = 1'b0, mv = 1'b1, mfs = 1'b0, cv = 1'b0, cl = 1'b0, rv = 1'b0;
	logic hwv, hrd, rwv, rir, corv, ovr, dla, uf;
	logic [15:0] hw, rw, w, cw = 16'h0000;
	logic signed [23:0] dd = 24'h000000, rdat = 24'h123456, cord;
	int n_mismatch = 0;
	int compares = 0;
	int i;
	always #10 ref_clk = ~ref_clk;
	acs_regs uut (.ref_clk(ref_clk), .rst(rst), .host_word_valid(hwv), .host_word(hw),
		.host_read(hrd), .conversion_valid_flag(cvf), .dec1_valid(dv), .dec1_data(dd),
		.mod_valid(mv), .mod_full_scale(mfs), .coef_pass_valid(cv), .coef_pass_word(cw),
		.coef_pass_last(cl), .result_valid(rv), .result_data(rdat),
		.read_word_valid_reg(rwv), .read_is_reg_reg(rir), .read_word_reg(rw),
		.corr_valid(corv), .corr_data(cord), .overrange_reg(ovr),
		.download_active_reg(dla), .user_filter_reg(uf));
	acs_host h (.ref_clk(ref_clk), .host_word_valid(hwv), .host_word(hw), .host_read(hrd),
		.read_word_valid_reg(rwv), .read_word_reg(rw));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stat(input logic [15:0] e);
		h.rd(16'h081a, w);
		chk("status", {8'h00, e}, {8'h00, w});
	endtask
	task automatic dec1(input logic [23:0] v, input logic e);
		@(negedge ref_clk);
		dv = 1'b1;
		dd = v;
		@(negedge ref_clk);
		dv = 1'b0;
		dd = ~v;
		chk("overrange", {23'h0, e}, {23'h0, ovr});
	endtask
	task automatic fast(input int n, input logic e);
		@(negedge ref_clk);
		mfs = 1'b1;
		repeat (n) @(negedge ref_clk);
		mfs = 1'b0;
		@(negedge ref_clk);
		chk("fast overrange", {23'h0, e}, {23'h0, ovr});
	endtask
	task automatic coef_pass;
		for (i = 1; i <= 8; i++) begin
			@(negedge ref_clk);
			cv = 1'b1;
			cw = i[15:0];
			cl = (i == 8);
		end
		@(negedge ref_clk);
		cv = 1'b0;
		cl = 1'b0;
		cw = ~cw;
	endtask
	task automatic results;
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		stat(16'h400a);
		h.rd(16'h101a, w);
		chk("offset", 24'h0, {8'h0, w});
		chk("read_is_reg", 24'h1, {23'h0, rir});
		h.rd(16'h201a, w);
		chk("gain", 24'ha000, {8'h0, w});
		h.rd(16'h401a, w);
		chk("threshold", 24'hcccc, {8'h0, w});
		h.rd(16'h0000, w);
		chk("result", 24'h1234, {8'h0, w});
		chk("read_is_reg", 24'h0, {23'h0, rir});
		h.wr(16'h0003, 16'h0001);
		h.wr(16'h0004, 16'h4000);
		h.rd(16'h201a, w);
		chk("gain", 24'h4000, {8'h0, w});
		@(negedge ref_clk);
		rv = 1'b1;
		rdat = 24'h0003e8;
		@(negedge ref_clk);
		rv = 1'b0;
		@(negedge ref_clk);
		chk("corr_valid", 24'h1, {23'h0, corv});
		// half gain then offset: 502, offset first would give 501
		chk("corr_data", 24'h0001f6, cord);
		h.wr(16'h0005, 16'h0100);
		dec1(24'h008080, 1'b1);
		stat(16'h410a);
		dec1(24'hff7f80, 1'b1);
		dec1(24'h008000, 1'b0);
		dec1(24'h800000, 1'b1);
		dec1(24'h000000, 1'b0);
		h.wr(16'h0001, 16'h801a);
		chk("download_active", 24'h1, {23'h0, dla});
		for (i = 1; i <= 8; i++) h.put(i[15:0]);
		h.put(16'h0024);
		chk("download_active", 24'h0, {23'h0, dla});
		chk("user_filter", 24'h1, {23'h0, uf});
		stat(16'h40aa);
		coef_pass();
		stat(16'h40ea);
		h.wr(16'h0001, 16'h801a);
		chk("user_filter", 24'h0, {23'h0, uf});
		for (i = 1; i <= 9; i++) h.put(i[15:0]);
		stat(16'h402a);
		cvf = 1'b1;
		h.wr(16'h0002, 16'h009f);
		for (i = 0; i < 6; i++) begin
			h.rd(16'h0808 | (i[0] ? 16'h0 : 16'h10) | i[15:0], w);
			chk("status", 24'h4628 | (i[0] ? 24'h10 : 24'h0) | i[23:0], {8'h0, w});
		end
		fast(4, 1'b0);
		fast(5, 1'b1);
		dec1(24'h000000, 1'b0);
		mv = 1'b0;
		fast(8, 1'b0);
		mv = 1'b1;
		results();
	end
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
